// ===== pkg/osc_cal_pkg.sv
// What this block does
// - Two separate calibration loops, one for the 2 MHz and one for the 32 MHz oscillator.
// - Per-loop reference bit: zero uses internal 32 kHz RC, one uses watch crystal.
// - An enabled loop keeps trimming its oscillator against the selected reference.
// - Sleep freezes loop state; after wake-up the loop continues from it.
// - A disabled loop keeps its last calibration value until enabled again.
// - Selecting a reference that is not stable is ignored.
// - Each loop holds a three-byte counter reference value in byte registers.
// - Counter reference values load from hardware at every reset.
// - Two-byte calibration value per loop, loaded by hardware at every reset.
// - The reset-loaded calibration value is where the loop starts adjusting.
// - Calibration starts at the first reference edge after the enable bit is set; the first step comes at the next one.
// - The 32 kHz RC trim changes only by software writes to its register and at reset, which loads 8'h80.
package osc_cal_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_LOOPS = 2;
  localparam int LOOP_SLOW = 0;
  localparam int LOOP_FAST = 1;
  localparam int CAL_W = 16;
  localparam int CNT_W = 24;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_REF_SEL = 8'h00;
  localparam logic [7:0] OFS_LOW_TRIM = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [3:0] PAGE_SLOW = 4'h1;
  localparam logic [3:0] PAGE_FAST = 4'h2;
  localparam logic [3:0] FLD_CTRL = 4'h0;
  localparam logic [3:0] FLD_CAL_LO = 4'h1;
  localparam logic [3:0] FLD_CAL_HI = 4'h2;
  localparam logic [3:0] FLD_CNT0 = 4'h3;
  localparam logic [3:0] FLD_CNT1 = 4'h4;
  localparam logic [3:0] FLD_CNT2 = 4'h5;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int SLOW_RC_REF_SEL_BIT = 0;
  localparam int FAST_RING_REF_SEL_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [1:0] REF_SEL_RST = 2'h0;
  localparam logic [7:0] LOW_TRIM_RST = 8'h80;
endpackage

// ===== verilog/osc_runtime_cal.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module osc_runtime_cal import osc_cal_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Oscillators and references, asynchronous
  input wire logic slow_osc_in,
  input wire logic fast_osc_in,
  input wire logic rc32k_in,
  input wire logic xtal32k_in,
  input wire logic rc32k_stable,
  input wire logic xtal32k_stable,
  // Power state, same clock
  input wire logic sleep,
  // Factory values taken after reset
  input wire logic [CAL_W-1:0] slow_factory_cal,
  input wire logic [CAL_W-1:0] fast_factory_cal,
  input wire logic [CNT_W-1:0] slow_factory_cnt,
  input wire logic [CNT_W-1:0] fast_factory_cnt,
  // Trim outputs
  output logic [CAL_W-1:0] slow_cal_out,
  output logic [CAL_W-1:0] fast_cal_out,
  output logic [7:0] low_rc_trim,
  output logic [1:0] loop_running
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CAL_W-1:0] step_cal(input logic [CAL_W-1:0] cal,
                                                input logic [CNT_W-1:0] meas,
                                                input logic [CNT_W-1:0] ref_cnt);
    logic [CAL_W-1:0] r;
    r = cal;
    // Too few edges means the oscillator is slow: raise the trim
    if (meas < ref_cnt && cal != {CAL_W{1'b1}}) begin
      r = cal + 1'b1;
    end else if (meas > ref_cnt && cal != '0) begin
      r = cal - 1'b1;
    end
    return r;
  endfunction

  function automatic logic [7:0] cnt_byte(input logic [CNT_W-1:0] v, input logic [3:0] fld);
    logic [7:0] r;
    r = 8'h00;
    case (fld)
      FLD_CNT0: r = v[7:0];
      FLD_CNT1: r = v[15:8];
      FLD_CNT2: r = v[23:16];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] async_in;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] rise;
  logic rc_ok;
  logic xtal_ok;

  assign async_in = {xtal32k_stable, rc32k_stable, xtal32k_in, rc32k_in, fast_osc_in,
                     slow_osc_in};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[3:0];
    end
  end

  // Edges are seen at clk rate, so the fast ring must arrive divided below clk/2
  assign rise = sync2_q[3:0] & ~sync3_q;
  assign rc_ok = sync2_q[4];
  assign xtal_ok = sync2_q[5];

  // ****************************************
  // Register decode
  // ****************************************
  logic [NUM_LOOPS-1:0] wr_loop;
  logic [3:0] fld;
  logic wr_ref_sel;
  logic wr_trim;

  assign fld = reg_addr[3:0];
  assign wr_loop[LOOP_SLOW] = reg_write && reg_addr[7:4] == PAGE_SLOW;
  assign wr_loop[LOOP_FAST] = reg_write && reg_addr[7:4] == PAGE_FAST;
  assign wr_ref_sel = reg_write && reg_addr == OFS_REF_SEL;
  assign wr_trim = reg_write && reg_addr == OFS_LOW_TRIM;

  // ****************************************
  // Reference select and trim
  // ****************************************
  logic [1:0] ref_sel_q;
  logic [7:0] trim_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_sel_q <= REF_SEL_RST;
    end else if (wr_ref_sel) begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        // An unstable source is never taken; the old choice stays
        if (reg_wdata[i] ? xtal_ok : rc_ok) begin
          ref_sel_q[i] <= reg_wdata[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_q <= LOW_TRIM_RST;
    end else if (wr_trim) begin
      trim_q <= reg_wdata;
    end
  end

  // ****************************************
  // Factory load after reset release
  // ****************************************
  logic load_q;
  logic [CAL_W-1:0] fac_cal [NUM_LOOPS];
  logic [CNT_W-1:0] fac_cnt [NUM_LOOPS];

  assign fac_cal[LOOP_SLOW] = slow_factory_cal;
  assign fac_cal[LOOP_FAST] = fast_factory_cal;
  assign fac_cnt[LOOP_SLOW] = slow_factory_cnt;
  assign fac_cnt[LOOP_FAST] = fast_factory_cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  // ****************************************
  // Loops
  // ****************************************
  logic [NUM_LOOPS-1:0] en_q;
  logic [NUM_LOOPS-1:0] started_q;
  logic [NUM_LOOPS-1:0] ref_edge;
  logic [NUM_LOOPS-1:0] osc_edge;
  logic [NUM_LOOPS-1:0] adj;
  logic [CAL_W-1:0] cal_q [NUM_LOOPS];
  logic [CNT_W-1:0] cnt_ref_q [NUM_LOOPS];
  logic [CNT_W-1:0] meas_q [NUM_LOOPS];

  always_comb begin
    for (int i = 0; i < NUM_LOOPS; i++) begin
      ref_edge[i] = ref_sel_q[i] ? rise[3] : rise[2];
      osc_edge[i] = rise[i];
      adj[i] = en_q[i] && !sleep && started_q[i] && ref_edge[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= '0;
    end else begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        if (wr_loop[i] && fld == FLD_CTRL) begin
          en_q[i] <= reg_wdata[CTRL_EN_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      started_q <= '0;
    end else begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        if (!en_q[i]) begin
          started_q[i] <= 1'b0;
        end else if (!sleep && ref_edge[i]) begin
          started_q[i] <= 1'b1;
        end
      end
    end
  end

  // Measurement window runs from one reference edge to the next
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        meas_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        if (!en_q[i]) begin
          meas_q[i] <= '0;
        end else if (sleep) begin
          meas_q[i] <= meas_q[i];
        end else if (ref_edge[i]) begin
          meas_q[i] <= '0;
        end else if (osc_edge[i] && meas_q[i] != {CNT_W{1'b1}}) begin
          meas_q[i] <= meas_q[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        cal_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        if (load_q) begin
          cal_q[i] <= fac_cal[i];
        end else if (wr_loop[i] && fld == FLD_CAL_LO) begin
          cal_q[i][7:0] <= reg_wdata;
        end else if (wr_loop[i] && fld == FLD_CAL_HI) begin
          cal_q[i][15:8] <= reg_wdata;
        end else if (adj[i]) begin
          cal_q[i] <= step_cal(cal_q[i], meas_q[i], cnt_ref_q[i]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        cnt_ref_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        if (load_q) begin
          cnt_ref_q[i] <= fac_cnt[i];
        end else if (wr_loop[i] && fld == FLD_CNT0) begin
          cnt_ref_q[i][7:0] <= reg_wdata;
        end else if (wr_loop[i] && fld == FLD_CNT1) begin
          cnt_ref_q[i][15:8] <= reg_wdata;
        end else if (wr_loop[i] && fld == FLD_CNT2) begin
          cnt_ref_q[i][23:16] <= reg_wdata;
        end
      end
    end
  end

  assign slow_cal_out = cal_q[LOOP_SLOW];
  assign fast_cal_out = cal_q[LOOP_FAST];
  assign low_rc_trim = trim_q;
  assign loop_running = en_q & started_q;

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_q;
  logic [7:0] rd_d;
  logic rd_hit;
  int rd_idx;

  always_comb begin
    rd_d = 8'h00;
    rd_hit = 1'b0;
    rd_idx = LOOP_SLOW;
    if (reg_addr[7:4] == PAGE_FAST) begin
      rd_idx = LOOP_FAST;
    end
    if (reg_addr == OFS_REF_SEL) begin
      rd_d = {6'h00, ref_sel_q};
    end else if (reg_addr == OFS_LOW_TRIM) begin
      rd_d = trim_q;
    end else if (reg_addr == OFS_STATUS) begin
      rd_d = {4'h0, xtal_ok, rc_ok, en_q & started_q};
    end else if (reg_addr[7:4] == PAGE_SLOW || reg_addr[7:4] == PAGE_FAST) begin
      rd_hit = 1'b1;
    end
    if (rd_hit) begin
      case (fld)
        FLD_CTRL: rd_d = {7'h00, en_q[rd_idx]};
        FLD_CAL_LO: rd_d = cal_q[rd_idx][7:0];
        FLD_CAL_HI: rd_d = cal_q[rd_idx][15:8];
        default: rd_d = cnt_byte(cnt_ref_q[rd_idx], fld);
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (reg_read) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_ref_reject;
    @(posedge clk) disable iff (!reset_n)
    wr_ref_sel && reg_wdata[0] && !xtal_ok |=> ref_sel_q[0] == $past(ref_sel_q[0]);
  endproperty
  a_ref_reject: assert property (p_ref_reject) else $error("unstable reference taken");

  property p_ref_take;
    @(posedge clk) disable iff (!reset_n)
    wr_ref_sel && xtal_ok && reg_wdata[1] |=> ref_sel_q[1];
  endproperty
  a_ref_take: assert property (p_ref_take) else $error("stable reference not taken");

  property p_enable_start;
    @(posedge clk) disable iff (!reset_n)
    wr_loop[0] && fld == FLD_CTRL && reg_wdata[CTRL_EN_BIT] |=> en_q[0];
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("enable not taken");

  property p_hold_off;
    @(posedge clk) disable iff (!reset_n)
    !en_q[1] && !load_q && !wr_loop[1] |=> cal_q[1] == $past(cal_q[1]);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("disabled loop moved");

  property p_sleep_freeze;
    @(posedge clk) disable iff (!reset_n)
    sleep && en_q[0] && !wr_loop[0] ##1 en_q[0] |-> $stable(meas_q[0]) && $stable(cal_q[0]);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("sleep did not freeze");

  property p_step_up;
    @(posedge clk) disable iff (!reset_n)
    adj[0] && !wr_loop[0] && meas_q[0] < cnt_ref_q[0] && cal_q[0] != 16'hffff
    |=> cal_q[0] == $past(cal_q[0]) + 16'h0001;
  endproperty
  a_step_up: assert property (p_step_up) else $error("trim did not step up");

  property p_step_down;
    @(posedge clk) disable iff (!reset_n)
    adj[1] && !wr_loop[1] && meas_q[1] > cnt_ref_q[1] && cal_q[1] != 16'h0000
    |=> cal_q[1] == $past(cal_q[1]) - 16'h0001;
  endproperty
  a_step_down: assert property (p_step_down) else $error("trim did not step down");

  property p_factory;
    @(posedge clk) disable iff (!reset_n)
    load_q |=> cal_q[0] == $past(slow_factory_cal) && cnt_ref_q[1] == $past(fast_factory_cnt);
  endproperty
  a_factory: assert property (p_factory) else $error("factory load missing");

  property p_trim_hold;
    @(posedge clk) disable iff (!reset_n)
    !wr_trim |=> $stable(trim_q);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved on its own");

endmodule

// ===== bench/osc_runtime_cal_test.sv
`timescale 1ns/10ps
module osc_runtime_cal_test;
  import osc_cal_pkg::*;
  // ****************************************
  // Stimulus values
  // ****************************************
  localparam logic [CAL_W-1:0] SLOW_CAL0 = 16'h1234;
  localparam logic [CAL_W-1:0] FAST_CAL0 = 16'h8000;
  // Slow target far above the edge count and fast target far below it, so the
  // two loops are seen stepping in opposite directions
  localparam logic [CNT_W-1:0] SLOW_CNT0 = 24'h01_0203;
  localparam logic [CNT_W-1:0] FAST_CNT0 = 24'h00_0002;
  logic clk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] low_rc_trim;
  logic reg_write;
  logic reg_read;
  logic sleep;
  // Source levels start here so that the source process is their only driver
  logic slow_osc_in = 1'b0;
  logic fast_osc_in = 1'b0;
  logic rc32k_in = 1'b0;
  logic xtal32k_in = 1'b0;
  logic rc32k_stable;
  logic xtal32k_stable;
  logic [CAL_W-1:0] slow_cal_out;
  logic [CAL_W-1:0] fast_cal_out;
  logic [1:0] loop_running;
  logic [4:0] tick_q = 5'h00;
  int n_errors;
  int samples_checked;

  osc_runtime_cal i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .slow_osc_in(slow_osc_in),
    .fast_osc_in(fast_osc_in),
    .rc32k_in(rc32k_in),
    .xtal32k_in(xtal32k_in),
    .rc32k_stable(rc32k_stable),
    .xtal32k_stable(xtal32k_stable),
    .sleep(sleep),
    .slow_factory_cal(SLOW_CAL0),
    .fast_factory_cal(FAST_CAL0),
    .slow_factory_cnt(SLOW_CNT0),
    .fast_factory_cnt(FAST_CNT0),
    .slow_cal_out(slow_cal_out),
    .fast_cal_out(fast_cal_out),
    .low_rc_trim(low_rc_trim),
    .loop_running(loop_running)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // Oscillator and reference sources
  // ****************************************
  // Oscillators toggle every 2 clocks, references every 32: 16 edges per window
  always @(posedge clk) begin
    tick_q <= tick_q + 5'h01;
    if (tick_q[0]) begin
      slow_osc_in <= ~slow_osc_in;
      fast_osc_in <= ~fast_osc_in;
    end
    if (tick_q == 5'h00) begin
      rc32k_in <= ~rc32k_in;
      xtal32k_in <= ~xtal32k_in;
    end
  end

  // ****************************************
  // Access and checking tasks
  // ****************************************
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  // Bounded wait for the next calibration step of one loop
  task automatic wait_step(input logic fast, input logic [15:0] old, output logic [15:0] now);
    int i;
    now = old;
    for (i = 0; i < 1000 && now === old; i++) begin
      @(negedge clk);
      now = fast ? fast_cal_out : slow_cal_out;
    end
    if (now === old) begin
      n_errors++;
      $display("Error at %0t: seen %h expected a step from %h", $time, now, old);
      end_of_test();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] v;
    logic [15:0] w;
    n_errors = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sleep = 1'b0;
    rc32k_stable = 1'b1;
    xtal32k_stable = 1'b0;
    repeat (10) @(negedge clk);
    chk(low_rc_trim, 8'h80);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(slow_cal_out, SLOW_CAL0);
    chk(fast_cal_out, FAST_CAL0);
    rd_chk({PAGE_SLOW, FLD_CAL_LO}, SLOW_CAL0[7:0]);
    rd_chk({PAGE_FAST, FLD_CAL_HI}, FAST_CAL0[15:8]);
    rd_chk({PAGE_SLOW, FLD_CNT0}, SLOW_CNT0[7:0]);
    rd_chk({PAGE_SLOW, FLD_CNT1}, SLOW_CNT0[15:8]);
    rd_chk({PAGE_SLOW, FLD_CNT2}, SLOW_CNT0[23:16]);
    rd_chk({PAGE_FAST, FLD_CNT0}, FAST_CNT0[7:0]);
    rd_chk(OFS_REF_SEL, {6'h00, REF_SEL_RST});
    // Unmapped place reads as zero
    rd_chk(8'h3f, 8'h00);
    wr(OFS_LOW_TRIM, 8'h5a);
    rd_chk(OFS_LOW_TRIM, 8'h5a);
    // Crystal not yet stable: selecting it must be ignored
    // Both bits ask for the crystal, so both loops see the refusal
    wr(OFS_REF_SEL, 8'h03);
    rd_chk(OFS_REF_SEL, 8'h00);
    rd_chk(OFS_STATUS, 8'h04);
    @(posedge clk);
    xtal32k_stable <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(OFS_STATUS, 8'h0c);
    wr(OFS_REF_SEL, 8'h02);
    rd_chk(OFS_REF_SEL, 8'h02);
    @(posedge clk);
    rc32k_stable <= 1'b0;
    repeat (4) @(posedge clk);
    wr(OFS_REF_SEL, 8'h00);
    rd_chk(OFS_REF_SEL, 8'h02);
    @(posedge clk);
    rc32k_stable <= 1'b1;
    repeat (4) @(posedge clk);
    wr({PAGE_SLOW, FLD_CTRL}, 8'h01);
    wait_step(1'b0, SLOW_CAL0, v);
    chk(v, SLOW_CAL0 + 16'h0001);
    chk(loop_running, 2'b01);
    wait_step(1'b0, v, w);
    chk(w, v + 16'h0001);
    wr({PAGE_FAST, FLD_CTRL}, 8'h01);
    wait_step(1'b1, FAST_CAL0, v);
    chk(v, FAST_CAL0 - 16'h0001);
    // Sleep: both loops frozen, then resume without restarting
    @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(negedge clk);
    v = slow_cal_out;
    w = fast_cal_out;
    repeat (300) @(negedge clk);
    chk(slow_cal_out, v);
    chk(fast_cal_out, w);
    @(posedge clk);
    sleep <= 1'b0;
    wait_step(1'b0, v, w);
    chk(w, v + 16'h0001);
    // Disable the slow loop only; the fast loop keeps stepping
    wr({PAGE_SLOW, FLD_CTRL}, 8'h00);
    repeat (3) @(negedge clk);
    v = slow_cal_out;
    w = fast_cal_out;
    repeat (300) @(negedge clk);
    chk(slow_cal_out, v);
    chk(loop_running[0], 1'b0);
    chk(fast_cal_out !== w, 1'b1);
    wr({PAGE_SLOW, FLD_CTRL}, 8'h01);
    wait_step(1'b0, v, w);
    chk(w, v + 16'h0001);
    chk(loop_running, 2'b11);
    chk(low_rc_trim, 8'h5a);
    // Mid-run reset reloads the hardware values
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(slow_cal_out, SLOW_CAL0);
    rd_chk({PAGE_FAST, FLD_CNT0}, FAST_CNT0[7:0]);
    rd_chk(OFS_LOW_TRIM, LOW_TRIM_RST);
    end_of_test();
  end
endmodule
